// [pkg/panel_route_regs.vh]
// Constants for the panel command placement and bypass routing block.
// Assumes it is included by bare name from the design files only.
`ifndef PANEL_ROUTE_REGS_VH
`define PANEL_ROUTE_REGS_VH
`define CMD_FMT_WIDTH 2
`define CMD_FMT_16 2'h0
`define CMD_FMT_8X2 2'h1
`define CMD_FMT_5_11 2'h2
`define BYP_MODE_WIDTH 4
`define BYP_MODE_RESET 4'hf
`define BYP_SER_P2 4'h4
`define BYP_SER_P1 4'h6
`define BYP_PAR16_P1 4'h2
`define BYP_PAR16_P2 4'h0
`define BYP_PAR511_P1 4'h3
`define BYP_PAR511_P2 4'h1
`define BYP_PAR88_P1 4'hb
`define BYP_PAR88_P2 4'h9
`define BYP_GPIO_P2 4'h8
`define PANEL_DATA_WIDTH 18
`define WORD_WIDTH 16
`define FIFO_DEPTH 4
`define FIFO_PTR_WIDTH 2
`endif

// [hw/word_fifo.v]
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an asynchronous active-low reset.
module word_fifo #(
  parameter WIDTH = 17,
  parameter DEPTH = 4,
  parameter PTR_WIDTH = 2
) (
  input wire clk_in,
  input wire reset_n_in,
  input wire in_valid_in,
  output wire in_ready_out,
  input wire [WIDTH-1:0] in_data_in,
  output wire out_valid_out,
  input wire out_ready_in,
  output wire [WIDTH-1:0] out_data_out
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [PTR_WIDTH-1:0] wr_ptr;
  reg [PTR_WIDTH-1:0] rd_ptr;
  reg [PTR_WIDTH:0] count;
  wire push;
  wire pop;
  assign in_ready_out = (count != DEPTH[PTR_WIDTH:0]);
  assign out_valid_out = (count != {(PTR_WIDTH+1){1'b0}});
  assign out_data_out = mem[rd_ptr];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;
  always @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_ptr <= {PTR_WIDTH{1'b0}};
      rd_ptr <= {PTR_WIDTH{1'b0}};
      count <= {(PTR_WIDTH+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + {{(PTR_WIDTH-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr <= rd_ptr + {{(PTR_WIDTH-1){1'b0}}, 1'b1};
      end
      if (push && !pop) begin
        count <= count + {{PTR_WIDTH{1'b0}}, 1'b1};
      end else if (pop && !push) begin
        count <= count - {{PTR_WIDTH{1'b0}}, 1'b1};
      end
    end
  end
endmodule

// [hw/panel_route.v]
// Panel command/parameter placement on the shared data pins and host bypass routing to both ports.
// Assumes host pins are asynchronous and pass a three-stage synchroniser; mode and
// format settings come from the register block on the same clock.
`include "panel_route_regs.vh"
module panel_route (
  // Clock and reset
  input wire CORE_CLK_IN,
  input wire RESET_N_IN,
  // Configuration
  input wire [1:0] CMD_FORMAT_IN,
  input wire [3:0] BYPASS_MODE_IN,
  input wire CS_MODE_IN,
  // Command and parameter words from the controller
  input wire WORD_VALID_IN,
  input wire WORD_IS_PARAM_IN,
  input wire [15:0] WORD_DATA_IN,
  output wire WORD_READY_OUT,
  // Normal display controller pin values
  input wire [17:0] CTRL_DATA_IN,
  input wire CTRL_LINE_IN,
  input wire CTRL_FRAME_IN,
  input wire CTRL_DRDY_IN,
  input wire CTRL_SEL1_N_IN,
  input wire CTRL_SEL2_N_IN,
  // Host bypass pins
  input wire HOST_BYPASS_SELECT_N_IN,
  input wire HOST_CHIP_SELECT_N_IN,
  input wire HOST_CMD_FLAG_IN,
  input wire HOST_WRITE_N_IN,
  input wire HOST_READ_N_IN,
  input wire HOST_SERIAL_CLOCK_IN,
  input wire HOST_SERIAL_IN_IN,
  input wire [15:0] HOST_DATA_IN,
  // Panel pins
  output reg [17:0] PANEL_DATA_PINS_OUT,
  output reg LINE_PULSE_PIN_OUT,
  output reg FRAME_PULSE_PIN_OUT,
  output reg DATA_VALID_PIN_OUT,
  output reg PANEL1_SELECT_N_OUT,
  output reg PANEL2_SELECT_N_OUT,
  output reg PANEL_SERIAL_CLOCK_OUT,
  output reg PANEL_SERIAL_CMD_FLAG_OUT,
  output reg PANEL_SERIAL_OUT_OUT,
  output reg [17:0] GPIO_OUT,
  output reg [17:0] GPIO_OE_OUT,
  // Status
  output reg INTERNAL_ACCESS_N_OUT,
  output reg BYPASS_ACTIVE_OUT,
  output reg WORD_STROBE_OUT,
  output reg WORD_IS_PARAM_OUT
);
  localparam SYNC_W = 22;
  localparam ST_IDLE = 2'h0;
  localparam ST_DRIVE = 2'h1;
  localparam ST_HOLD = 2'h2;

  // Word placement shared by all command formats; parameters use it too.
  function [17:0] place_word;
    input [1:0] fmt;
    input [15:0] w;
    begin
      case (fmt)
        `CMD_FMT_16: place_word = {2'h0, w};
        `CMD_FMT_8X2: place_word = {w[15:8], 1'b0, w[7:0], 1'b0};
        `CMD_FMT_5_11: place_word = {w[15:11], 1'b0, w[10:0], 1'b0};
        default: place_word = {2'h0, w};
      endcase
    end
  endfunction

  // Host data placement for parallel bypass widths.
  function [17:0] place_host;
    input [3:0] mode;
    input [15:0] w;
    begin
      case (mode)
        `BYP_PAR511_P1, `BYP_PAR511_P2: place_host = {w[15:11], 1'b0, w[10:0], 1'b0};
        `BYP_PAR88_P1, `BYP_PAR88_P2: place_host = {w[15:8], 1'b0, w[7:0], 1'b0};
        default: place_host = {2'h0, w};
      endcase
    end
  endfunction

  // Three stages; a change counts only once stages two and three agree.
  reg [SYNC_W-1:0] sync1;
  reg [SYNC_W-1:0] sync2;
  reg [SYNC_W-1:0] sync3;
  reg [SYNC_W-1:0] host;
  wire [SYNC_W-1:0] raw = {HOST_DATA_IN, HOST_SERIAL_IN_IN, HOST_SERIAL_CLOCK_IN,
                           HOST_READ_N_IN, HOST_WRITE_N_IN, HOST_CMD_FLAG_IN,
                           HOST_CHIP_SELECT_N_IN};
  integer i;
  always @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      sync1 <= {SYNC_W{1'b1}};
      sync2 <= {SYNC_W{1'b1}};
      sync3 <= {SYNC_W{1'b1}};
      host <= {SYNC_W{1'b1}};
    end else begin
      sync1 <= raw;
      sync2 <= sync1;
      sync3 <= sync2;
      for (i = 0; i < SYNC_W; i = i + 1) begin
        if (sync2[i] == sync3[i]) begin
          host[i] <= sync3[i];
        end
      end
    end
  end
  reg bsel_s1;
  reg bsel_s2;
  reg bsel_s3;
  reg bsel;
  always @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      bsel_s1 <= 1'b1;
      bsel_s2 <= 1'b1;
      bsel_s3 <= 1'b1;
      bsel <= 1'b1;
    end else begin
      bsel_s1 <= HOST_BYPASS_SELECT_N_IN;
      bsel_s2 <= bsel_s1;
      bsel_s3 <= bsel_s2;
      if (bsel_s2 == bsel_s3) begin
        bsel <= bsel_s3;
      end
    end
  end
  wire h_cs_n = host[0];
  wire h_flag = host[1];
  wire h_wr_n = host[2];
  wire h_rd_n = host[3];
  wire h_sck = host[4];
  wire h_si = host[5];
  wire [15:0] h_data = host[21:6];

  // Command word path through the FIFO; the drain holds each word two cycles.
  wire fifo_valid;
  wire [16:0] fifo_data;
  reg [1:0] state;
  reg [1:0] next_state;
  wire fifo_pop = (state == ST_HOLD);
  word_fifo #(
    .WIDTH(17),
    .DEPTH(`FIFO_DEPTH),
    .PTR_WIDTH(`FIFO_PTR_WIDTH)
  ) u_fifo (
    .clk_in(CORE_CLK_IN),
    .reset_n_in(RESET_N_IN),
    .in_valid_in(WORD_VALID_IN),
    .in_ready_out(WORD_READY_OUT),
    .in_data_in({WORD_IS_PARAM_IN, WORD_DATA_IN}),
    .out_valid_out(fifo_valid),
    .out_ready_in(fifo_pop),
    .out_data_out(fifo_data)
  );
  wire is_bypass;
  always @* begin
    case (state)
      ST_IDLE: next_state = (fifo_valid && !is_bypass) ? ST_DRIVE : ST_IDLE;
      ST_DRIVE: next_state = ST_HOLD;
      ST_HOLD: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  // Bypass decode; unlisted codes fall back to the display controller.
  reg is_serial;
  reg is_par;
  reg is_gpio;
  reg to_port1;
  always @* begin
    is_serial = 1'b0;
    is_par = 1'b0;
    is_gpio = 1'b0;
    to_port1 = 1'b0;
    case (BYPASS_MODE_IN)
      `BYP_SER_P2: is_serial = 1'b1;
      `BYP_SER_P1: begin
        is_serial = 1'b1;
        to_port1 = 1'b1;
      end
      `BYP_PAR16_P1, `BYP_PAR511_P1, `BYP_PAR88_P1: begin
        is_par = 1'b1;
        to_port1 = 1'b1;
      end
      `BYP_PAR16_P2, `BYP_PAR511_P2, `BYP_PAR88_P2: is_par = 1'b1;
      `BYP_GPIO_P2: is_gpio = 1'b1;
      default: to_port1 = 1'b0;
    endcase
  end
  assign is_bypass = is_serial | is_par | is_gpio;

  // Panel select: mode 0 passes bypass select, mode 1 gates chip select with it.
  wire bypass_sel_n = CS_MODE_IN ? (bsel | h_cs_n) : bsel;
  wire internal_n = CS_MODE_IN ? (h_cs_n | !bsel) : h_cs_n;

  always @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      state <= ST_IDLE;
      PANEL_DATA_PINS_OUT <= 18'h00000;
      LINE_PULSE_PIN_OUT <= 1'b0;
      FRAME_PULSE_PIN_OUT <= 1'b0;
      DATA_VALID_PIN_OUT <= 1'b0;
      PANEL1_SELECT_N_OUT <= 1'b1;
      PANEL2_SELECT_N_OUT <= 1'b1;
      PANEL_SERIAL_CLOCK_OUT <= 1'b0;
      PANEL_SERIAL_CMD_FLAG_OUT <= 1'b0;
      PANEL_SERIAL_OUT_OUT <= 1'b0;
      GPIO_OUT <= 18'h00000;
      GPIO_OE_OUT <= 18'h00000;
      INTERNAL_ACCESS_N_OUT <= 1'b1;
      BYPASS_ACTIVE_OUT <= 1'b0;
      WORD_STROBE_OUT <= 1'b0;
      WORD_IS_PARAM_OUT <= 1'b0;
    end else begin
      state <= next_state;
      BYPASS_ACTIVE_OUT <= is_bypass;
      INTERNAL_ACCESS_N_OUT <= internal_n;
      WORD_STROBE_OUT <= (next_state == ST_DRIVE);
      GPIO_OUT <= 18'h00000;
      GPIO_OE_OUT <= 18'h00000;
      PANEL_SERIAL_CLOCK_OUT <= 1'b0;
      PANEL_SERIAL_CMD_FLAG_OUT <= 1'b0;
      PANEL_SERIAL_OUT_OUT <= 1'b0;
      if (is_bypass) begin
        PANEL1_SELECT_N_OUT <= to_port1 ? bypass_sel_n : 1'b1;
        PANEL2_SELECT_N_OUT <= to_port1 ? 1'b1 : bypass_sel_n;
      end else begin
        PANEL1_SELECT_N_OUT <= CTRL_SEL1_N_IN;
        PANEL2_SELECT_N_OUT <= CTRL_SEL2_N_IN;
      end
      if (is_serial) begin
        // Serial lines follow the host; parallel pins sit idle.
        PANEL_SERIAL_CLOCK_OUT <= h_sck;
        PANEL_SERIAL_CMD_FLAG_OUT <= h_flag;
        PANEL_SERIAL_OUT_OUT <= h_si;
        PANEL_DATA_PINS_OUT <= 18'h00000;
        LINE_PULSE_PIN_OUT <= 1'b0;
        FRAME_PULSE_PIN_OUT <= 1'b0;
        DATA_VALID_PIN_OUT <= 1'b0;
      end else if (is_par) begin
        LINE_PULSE_PIN_OUT <= h_flag;
        FRAME_PULSE_PIN_OUT <= h_wr_n;
        DATA_VALID_PIN_OUT <= h_rd_n;
        PANEL_DATA_PINS_OUT <= place_host(BYPASS_MODE_IN, h_data);
      end else if (is_gpio) begin
        // No read strobe in this mode, so general pins 17 to 8 only ever drive; pins 7 to 0 are never enabled.
        GPIO_OUT <= {h_data[7:0], h_wr_n, h_flag, 8'h00};
        GPIO_OE_OUT <= 18'h3ff00;
        PANEL_DATA_PINS_OUT <= 18'h00000;
        LINE_PULSE_PIN_OUT <= 1'b0;
        FRAME_PULSE_PIN_OUT <= 1'b0;
        DATA_VALID_PIN_OUT <= 1'b0;
      end else if (next_state == ST_DRIVE || state == ST_DRIVE) begin
        PANEL_DATA_PINS_OUT <= place_word(CMD_FORMAT_IN, fifo_data[15:0]);
        WORD_IS_PARAM_OUT <= fifo_data[16];
        LINE_PULSE_PIN_OUT <= CTRL_LINE_IN;
        FRAME_PULSE_PIN_OUT <= CTRL_FRAME_IN;
        DATA_VALID_PIN_OUT <= CTRL_DRDY_IN;
      end else begin
        PANEL_DATA_PINS_OUT <= CTRL_DATA_IN;
        LINE_PULSE_PIN_OUT <= CTRL_LINE_IN;
        FRAME_PULSE_PIN_OUT <= CTRL_FRAME_IN;
        DATA_VALID_PIN_OUT <= CTRL_DRDY_IN;
      end
    end
  end
endmodule

// [testbench/panel_route_asserts.sv]
// Checker bound into panel_route: word placement, bypass status and select arbitration.
// Assumes host inputs held for eight cycles have passed the input synchroniser.
module panel_route_asserts (
  // Clock, reset, settings and host selects
  input wire logic CORE_CLK_IN,
  input wire logic RESET_N_IN,
  input wire logic [1:0] CMD_FORMAT_IN,
  input wire logic [3:0] BYPASS_MODE_IN,
  input wire logic CS_MODE_IN,
  input wire logic HOST_BYPASS_SELECT_N_IN,
  input wire logic HOST_CHIP_SELECT_N_IN,
  // Observed outputs
  input wire logic [17:0] PANEL_DATA_PINS_OUT,
  input wire logic PANEL1_SELECT_N_OUT,
  input wire logic PANEL2_SELECT_N_OUT,
  input wire logic INTERNAL_ACCESS_N_OUT,
  input wire logic BYPASS_ACTIVE_OUT,
  input wire logic WORD_STROBE_OUT
);
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RESET_N_IN);
  wire listed = BYPASS_MODE_IN inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h8, 4'h9, 4'hb};
  // Format 3 stands for no word shown, so none of the placement checks fire.
  wire [1:0] fmt = WORD_STROBE_OUT ? CMD_FORMAT_IN : 2'h3;
  sequence s_sel_high; (CS_MODE_IN && HOST_BYPASS_SELECT_N_IN && BYPASS_ACTIVE_OUT) [*8]; endsequence
  sequence s_listed; listed ##1 listed; endsequence
  property p_fmt0; fmt == 2'h0 |-> PANEL_DATA_PINS_OUT[17:16] == 2'h0; endproperty
  a_fmt0: assert property (p_fmt0) else $error("format 0 idle lines");
  property p_fmt1; fmt == 2'h1 |-> !PANEL_DATA_PINS_OUT[9] && !PANEL_DATA_PINS_OUT[0]; endproperty
  a_fmt1: assert property (p_fmt1) else $error("format 1 idle lines");
  property p_fmt2; fmt == 2'h2 |-> !PANEL_DATA_PINS_OUT[12] && !PANEL_DATA_PINS_OUT[0]; endproperty
  a_fmt2: assert property (p_fmt2) else $error("format 2 idle lines");
  property p_hold; $rose(WORD_STROBE_OUT) |=> !WORD_STROBE_OUT && $stable(PANEL_DATA_PINS_OUT); endproperty
  a_hold: assert property (p_hold) else $error("word not held two cycles");
  property p_on; s_listed |-> BYPASS_ACTIVE_OUT; endproperty
  a_on: assert property (p_on) else $error("listed code not active");
  property p_off; !listed ##1 !listed |-> !BYPASS_ACTIVE_OUT; endproperty
  a_off: assert property (p_off) else $error("unlisted code active");
  property p_pass;
    (!CS_MODE_IN && BYPASS_MODE_IN == 4'h2 && $stable(HOST_BYPASS_SELECT_N_IN)) [*8]
      |-> PANEL1_SELECT_N_OUT == HOST_BYPASS_SELECT_N_IN;
  endproperty
  a_pass: assert property (p_pass) else $error("bypass select not passed");
  property p_fwd;
    (CS_MODE_IN && !HOST_BYPASS_SELECT_N_IN && BYPASS_MODE_IN == 4'h2
      && $stable(HOST_CHIP_SELECT_N_IN)) [*8] |-> PANEL1_SELECT_N_OUT == HOST_CHIP_SELECT_N_IN;
  endproperty
  a_fwd: assert property (p_fwd) else $error("chip select not forwarded");
  property p_cs_hi; s_sel_high |-> PANEL1_SELECT_N_OUT && PANEL2_SELECT_N_OUT; endproperty
  a_cs_hi: assert property (p_cs_hi) else $error("panel select asserted");
  property p_int;
    (CS_MODE_IN && HOST_BYPASS_SELECT_N_IN && !HOST_CHIP_SELECT_N_IN) [*8] |-> !INTERNAL_ACCESS_N_OUT;
  endproperty
  a_int: assert property (p_int) else $error("internal access missing");
endmodule
bind panel_route panel_route_asserts chk_u (.*);

// [testbench/host_pins_model.sv]
// Host processor model: drives the bypass code and the asynchronous host bypass pins.
// Assumes one caller of put(); pins move 1 ns after a rising edge.
module host_pins_model (
  // Clock
  input wire logic clk_in,
  // Code, select, chip select, flag, write, read, serial clock, serial data, data
  output logic [26:0] pins_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial pins_out = {4'hf, 7'h6c, 16'h0000};
  // A deselected host stops driving data, so stale data must not linger on the lines.
  task automatic put(input logic [3:0] m, input logic [6:0] c, input logic [15:0] d);
    @(posedge clk_in);
    #1 pins_out = {m, c, c[6] ? ~pins_out[15:0] : d};
  endtask
endmodule

// [testbench/panel_route_test.sv]
// Bench for panel_route: placement, buffering, bypass routing and select arbitration.
// Assumes host_pins_model drives the host pins and the checker is bound in.
module panel_route_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic CORE_CLK_IN, RESET_N_IN, CS_MODE_IN, WORD_VALID_IN, WORD_IS_PARAM_IN;
  logic [1:0] CMD_FORMAT_IN;
  logic [15:0] WORD_DATA_IN;
  logic [17:0] CTRL_DATA_IN;
  logic CTRL_LINE_IN = 0, CTRL_FRAME_IN = 0, CTRL_DRDY_IN = 0, CTRL_SEL1_N_IN = 1;
  logic CTRL_SEL2_N_IN = 1;
  wire [3:0] BYPASS_MODE_IN;
  wire HOST_BYPASS_SELECT_N_IN, HOST_CHIP_SELECT_N_IN, HOST_CMD_FLAG_IN, HOST_WRITE_N_IN;
  wire HOST_READ_N_IN, HOST_SERIAL_CLOCK_IN, HOST_SERIAL_IN_IN;
  wire [15:0] HOST_DATA_IN;
  wire [26:0] host_pins;
  logic [17:0] PANEL_DATA_PINS_OUT, GPIO_OUT, GPIO_OE_OUT;
  logic WORD_READY_OUT, LINE_PULSE_PIN_OUT, FRAME_PULSE_PIN_OUT, DATA_VALID_PIN_OUT;
  logic PANEL1_SELECT_N_OUT, PANEL2_SELECT_N_OUT, PANEL_SERIAL_CLOCK_OUT;
  logic PANEL_SERIAL_CMD_FLAG_OUT, PANEL_SERIAL_OUT_OUT, INTERNAL_ACCESS_N_OUT;
  logic BYPASS_ACTIVE_OUT, WORD_STROBE_OUT, WORD_IS_PARAM_OUT;
  int errors = 0;
  int n_checks = 0;
  int cycles = 0;
  assign {BYPASS_MODE_IN, HOST_BYPASS_SELECT_N_IN, HOST_CHIP_SELECT_N_IN, HOST_CMD_FLAG_IN,
    HOST_WRITE_N_IN, HOST_READ_N_IN, HOST_SERIAL_CLOCK_IN, HOST_SERIAL_IN_IN,
    HOST_DATA_IN} = host_pins;
  panel_route dut_u (.*);
  host_pins_model host_u (.clk_in(CORE_CLK_IN), .pins_out(host_pins));
  // Line placement of a word; bypass buses reuse it (0 for 16 lines, 1 for 8+8, 2 for 5+11).
  function automatic logic [17:0] place(input logic [1:0] f, input logic [15:0] w);
    case (f)
      2'h1: place = {w[15:8], 1'b0, w[7:0], 1'b0};
      2'h2: place = {w[15:11], 1'b0, w[10:0], 1'b0};
      default: place = {2'h0, w};
    endcase
  endfunction
  task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("%0d checks, %0d mismatches", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic push(input logic p, input logic [15:0] w);
    @(posedge CORE_CLK_IN);
    #1 {WORD_VALID_IN, WORD_IS_PARAM_IN, WORD_DATA_IN} = {1'b1, p, w};
    do @(posedge CORE_CLK_IN); while (WORD_READY_OUT !== 1'b1);
    #1 WORD_VALID_IN = 0;
  endtask
  task automatic expect_word(input logic p, input logic [17:0] e);
    int i;
    i = 0;
    // Look just after the edge, once the strobe and the word have settled.
    do begin
      @(posedge CORE_CLK_IN);
      #1;
      i++;
    end while (WORD_STROBE_OUT !== 1'b1 && i < 40);
    chk({WORD_IS_PARAM_OUT, PANEL_DATA_PINS_OUT}, {p, e});
    // Let the strobe cycle pass so a format change cannot meet a word still shown.
    @(posedge CORE_CLK_IN);
  endtask
  task automatic route(input logic [3:0] m, input logic [6:0] c, input logic [15:0] d);
    host_u.put(m, c, d);
    repeat (8) @(posedge CORE_CLK_IN);
  endtask
  initial begin
    CORE_CLK_IN = 0;
    forever #5 CORE_CLK_IN = ~CORE_CLK_IN;
  end
  always @(posedge CORE_CLK_IN) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      tally_and_finish;
    end
  end
  initial begin
    {RESET_N_IN, CS_MODE_IN, WORD_VALID_IN, WORD_IS_PARAM_IN, CMD_FORMAT_IN} = 0;
    WORD_DATA_IN = 0;
    CTRL_DATA_IN = 18'h2a5a5;
    repeat (3) @(posedge CORE_CLK_IN);
    #1 RESET_N_IN = 1;
    for (int f = 0; f < 3; f++) begin
      #1 CMD_FORMAT_IN = f[1:0];
      push(0, 16'hffff);
      expect_word(0, place(f[1:0], 16'hffff));
      push(1, 16'h5a81);
      expect_word(1, place(f[1:0], 16'h5a81));
    end
    $display("placement test done");
    // Words are held back while bypassing, so four pushes fill the queue.
    host_u.put(4'h2, 7'h2c, 16'h1234);
    for (int i = 0; i < 4; i++) push(i[0], {4{i[3:0]}});
    @(posedge CORE_CLK_IN);
    chk(WORD_READY_OUT, 0);
    for (int i = 0; i < 6; i++) begin
      route(24'h23b019 >> (20 - 4 * i), 7'h34, 16'h9c35);
      chk(PANEL_DATA_PINS_OUT & place(2'(3 - i % 3), 16'hffff), place(2'(3 - i % 3), 16'h9c35));
      chk({LINE_PULSE_PIN_OUT, FRAME_PULSE_PIN_OUT, DATA_VALID_PIN_OUT}, 3'b101);
      chk({PANEL1_SELECT_N_OUT, PANEL2_SELECT_N_OUT, INTERNAL_ACCESS_N_OUT}, i < 3 ? 3'h3 : 3'h5);
    end
    host_u.put(4'hf, 7'h6c, 16'h0000);
    for (int i = 0; i < 4; i++) expect_word(i[0], place(2'h2, {4{i[3:0]}}));
    $display("buffer and parallel bypass test done");
    for (int i = 0; i < 2; i++) begin
      route(i ? 4'h6 : 4'h4, {6'h1b, i[0]}, 16'h0000);
      chk({PANEL_SERIAL_CLOCK_OUT, PANEL_SERIAL_CMD_FLAG_OUT, PANEL_SERIAL_OUT_OUT}, {2'h3, i[0]});
      chk({PANEL1_SELECT_N_OUT, PANEL2_SELECT_N_OUT}, i ? 2'b01 : 2'b10);
    end
    route(4'h8, 7'h34, 16'h00c6);
    chk(GPIO_OE_OUT, 18'h3ff00);
    chk(GPIO_OUT[17:8], {8'hc6, 2'b01});
    #1 CTRL_DATA_IN = 18'h15a5a;
    route(4'h5, 7'h34, 16'h00c6);
    chk({BYPASS_ACTIVE_OUT, PANEL_DATA_PINS_OUT}, {1'b0, CTRL_DATA_IN});
    $display("serial, general pin and unlisted code test done");
    #1 CS_MODE_IN = 1;
    for (int i = 0; i < 3; i++) begin
      route(4'h2, i == 0 ? 7'h0c : i == 1 ? 7'h4c : 7'h2c, 16'h0000);
      chk({PANEL1_SELECT_N_OUT, INTERNAL_ACCESS_N_OUT}, i == 0 ? 2'b01 : i == 1 ? 2'b10 : 2'b11);
    end
    $display("chip select mode test done");
    tally_and_finish;
  end
endmodule
